//--- design/ioexp_pkg.sv
`default_nettype none

package ioexp_pkg;

  // ----------------------------------------------------------------
  // Command byte values, one per register
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_IN0  = 8'h00;
  localparam logic [7:0] CMD_IN1  = 8'h01;
  localparam logic [7:0] CMD_OUT0 = 8'h02;
  localparam logic [7:0] CMD_OUT1 = 8'h03;
  localparam logic [7:0] CMD_INV0 = 8'h04;
  localparam logic [7:0] CMD_INV1 = 8'h05;
  localparam logic [7:0] CMD_DIR0 = 8'h06;
  localparam logic [7:0] CMD_DIR1 = 8'h07;
  localparam logic [7:0] CMD_LAST = 8'h07;

  // ----------------------------------------------------------------
  // Command byte fields: bits 2:1 pick the register kind, bit 0 the port
  // ----------------------------------------------------------------
  localparam int         CMD_KIND_HI = 2;
  localparam int         CMD_KIND_LO = 1;
  localparam int         CMD_PORT    = 0;
  localparam logic [1:0] KIND_IN     = 2'h0;
  localparam logic [1:0] KIND_OUT    = 2'h1;
  localparam logic [1:0] KIND_INV    = 2'h2;
  localparam logic [1:0] KIND_DIR    = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_RST    = 8'hFF;
  localparam logic [7:0] INVERT_RST   = 8'h00;
  localparam logic [7:0] DIR_RST      = 8'hFF;
  localparam logic [7:0] PTR_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  // Seven-bit bus address; the value is arbitrary.
  localparam logic [6:0] SLAVE_ADDR   = 7'h27;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [3:0] BIT_DONE     = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] invert;
    logic [7:0] direction;
  } ioexp_port_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WR,
    ST_RD
  } ioexp_state_t;

endpackage

`default_nettype wire

//--- design/ioexp_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for levels arriving from outside the clock.
module ioexp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

`default_nettype wire

//--- design/ioexp_regs.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Commands 00h and 01h select the read-only input level bytes of port 0 and port 1.
// - Each input level bit shows the sampled pin level whatever the pin direction.
// - A write to an input level register changes nothing but is still acknowledged.
// - Commands 02h and 03h select the output latches, read/write, reset to all ones.
// - A latch bit drives its pin only while that pin is an output.
// - Reading a latch returns the stored value, not the pin level.
// - Commands 04h and 05h select the inversion registers, read/write, reset to zero.
// - A set inversion bit complements the reported level, a clear one passes it.
// - Inversion applies to the levels reported for input-direction pins.
// - Commands 06h and 07h select the direction registers, reset to all ones (inputs).
// - Direction one leaves the pin undriven, zero drives the latch level onto it.
// - The byte after the address is kept as the pointer selecting later data bytes.
// - Each further written byte goes to the other register of the pair, without limit.
// - Each further read byte comes from the other register of the pair; the master ends with no ack.
module ioexp_regs
  import ioexp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic [7:0] port0_pin_i,
  input  wire logic [7:0] port1_pin_i,
  output logic      [7:0] port0_pin_o,
  output logic      [7:0] port0_pin_oe,
  output logic      [7:0] port1_pin_o,
  output logic      [7:0] port1_pin_oe
);

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  logic [17:0] sync_s;
  logic        scl_s;
  logic        sda_s;
  logic [7:0]  pin_s [2];

  ioexp_sync #(
    .W (18)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .async_i ({scl_i, sda_i, port1_pin_i, port0_pin_i}),
    .sync_o  (sync_s)
  );

  // Bus lines and port pins after the two-stage crossing.
  assign scl_s    = sync_s[17];
  assign sda_s    = sync_s[16];
  assign pin_s[1] = sync_s[15:8];
  assign pin_s[0] = sync_s[7:0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ioexp_state_t st_r;
  ioexp_state_t st_nxt;
  ioexp_port_t  port_r [2];
  ioexp_port_t  port_nxt [2];
  logic [3:0]   cnt_r;
  logic [3:0]   cnt_nxt;
  logic [7:0]   sh_r;
  logic [7:0]   sh_nxt;
  logic [7:0]   ptr_r;
  logic [7:0]   ptr_nxt;
  logic         rw_r;
  logic         rw_nxt;
  logic         oe_r;
  logic         oe_nxt;
  logic         mack_r;
  logic         mack_nxt;
  logic         scl_d_r;
  logic         sda_d_r;
  logic         start_det;
  logic         stop_det;
  logic         scl_rise;
  logic         scl_fall;
  logic [7:0]   ptr_tog;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Reported input level: inversion only where the pin is an input.
  function automatic logic [7:0] level_of(input logic [7:0] pin, input ioexp_port_t p);
    level_of = pin ^ (p.invert & p.direction);
  endfunction

  // Byte returned for a read at the given pointer.
  function automatic logic [7:0] read_byte(input logic [7:0] ptr, input ioexp_port_t p0, input ioexp_port_t p1,
                                           input logic [7:0] pin0, input logic [7:0] pin1);
    ioexp_port_t p;
    logic [7:0]  pin;
    p   = ptr[CMD_PORT] ? p1 : p0;
    pin = ptr[CMD_PORT] ? pin1 : pin0;
    if (ptr > CMD_LAST)
    begin
      read_byte = UNMAPPED_VAL;
    end
    else
    begin
      case (ptr[CMD_KIND_HI:CMD_KIND_LO])
        KIND_IN:  read_byte = level_of(pin, p);
        KIND_OUT: read_byte = p.latch;
        KIND_INV: read_byte = p.invert;
        KIND_DIR: read_byte = p.direction;
        default:  read_byte = UNMAPPED_VAL;
      endcase
    end
  endfunction

  // Bus conditions seen on the synchronised lines.
  assign start_det = scl_s & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & ~sda_d_r & sda_s;
  assign scl_rise  = ~scl_d_r & scl_s;
  assign scl_fall  = scl_d_r & ~scl_s;
  // Pair partner: only bit 0 flips, so a pointer never leaves its pair.
  assign ptr_tog   = (ptr_r > CMD_LAST) ? ptr_r : {ptr_r[7:1], ~ptr_r[CMD_PORT]};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Bit counter runs 1..8 over data bits, 9 over the acknowledge bit.
  always_comb
  begin
    st_nxt   = st_r;
    port_nxt = port_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    ptr_nxt  = ptr_r;
    rw_nxt   = rw_r;
    oe_nxt   = oe_r;
    mack_nxt = mack_r;
    if (start_det)
    begin
      st_nxt  = ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end
    else if (stop_det)
    begin
      st_nxt  = ST_IDLE;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end
    else if (st_r != ST_IDLE && scl_rise)
    begin
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r < BIT_ACK && st_r != ST_RD)
      begin
        sh_nxt = {sh_r[6:0], sda_s};
      end
      else if (cnt_r == BIT_ACK && st_r == ST_RD)
      begin
        mack_nxt = ~sda_s;
      end
    end
    else if (st_r != ST_IDLE && scl_fall)
    begin
      if (cnt_r == BIT_ACK)
      begin
        // A whole byte has passed; act on it and drive or release acknowledge.
        case (st_r)
          ST_ADDR:
          begin
            if (sh_r[7:1] == SLAVE_ADDR)
            begin
              rw_nxt = sh_r[0];
              oe_nxt = 1'b1;
            end
            else
            begin
              st_nxt = ST_IDLE;
            end
          end
          ST_CMD:
          begin
            ptr_nxt = sh_r;
            oe_nxt  = 1'b1;
          end
          ST_WR:
          begin
            oe_nxt = 1'b1;
            if (ptr_r <= CMD_LAST)
            begin
              case (ptr_r[CMD_KIND_HI:CMD_KIND_LO])
                KIND_OUT: port_nxt[ptr_r[CMD_PORT]].latch     = sh_r;
                KIND_INV: port_nxt[ptr_r[CMD_PORT]].invert    = sh_r;
                KIND_DIR: port_nxt[ptr_r[CMD_PORT]].direction = sh_r;
                default:  port_nxt = port_r;
              endcase
            end
            ptr_nxt = ptr_tog;
          end
          ST_RD:
          begin
            oe_nxt  = 1'b0;
            ptr_nxt = ptr_tog;
          end
          default: st_nxt = ST_IDLE;
        endcase
      end
      else if (cnt_r == BIT_DONE)
      begin
        cnt_nxt = 4'h0;
        oe_nxt  = 1'b0;
        if ((st_r == ST_ADDR && rw_r) || (st_r == ST_RD && mack_r))
        begin
          // Present the next byte, most significant bit first.
          st_nxt = ST_RD;
          sh_nxt = read_byte(ptr_r, port_r[0], port_r[1], pin_s[0], pin_s[1]);
          oe_nxt = ~sh_nxt[7];
        end
        else if (st_r == ST_RD)
        begin
          st_nxt = ST_IDLE;
        end
        else if (st_r == ST_ADDR)
        begin
          st_nxt = ST_CMD;
        end
        else
        begin
          st_nxt = ST_WR;
        end
      end
      else if (st_r == ST_RD && cnt_r != 4'h0)
      begin
        sh_nxt = {sh_r[6:0], 1'b0};
        oe_nxt = ~sh_r[6];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Power-on values put every pin in the undriven input state.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r    <= ST_IDLE;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      ptr_r   <= PTR_RST;
      rw_r    <= 1'b0;
      oe_r    <= 1'b0;
      mack_r  <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
        port_r[i].latch     <= LATCH_RST;
        port_r[i].invert    <= INVERT_RST;
        port_r[i].direction <= DIR_RST;
      end
    end
    else
    begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      ptr_r   <= ptr_nxt;
      rw_r    <= rw_nxt;
      oe_r    <= oe_nxt;
      mack_r  <= mack_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      port_r  <= port_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // The data line is open drain: only ever pulled low.
  assign sda_o  = 1'b0;
  assign sda_oe = oe_r;

  // Latch drives the pin only where direction is zero.
  assign port0_pin_o  = port_r[0].latch;
  assign port0_pin_oe = ~port_r[0].direction;
  assign port1_pin_o  = port_r[1].latch;
  assign port1_pin_oe = ~port_r[1].direction;

endmodule

`default_nettype wire

//--- tb/ioexp_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the bus pins and port outputs of the expander.
module ioexp_asserts (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_oe,
  input wire logic [7:0] port0_pin_o,
  input wire logic [7:0] port0_pin_oe,
  input wire logic [7:0] port1_pin_o,
  input wire logic [7:0] port1_pin_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A register takes one byte per nine bus clocks, so outputs settle for long spans.
  sequence s_oe1_hold;
    $stable(port1_pin_oe)[*8];
  endsequence
  property p_rst_vals;
    $fell(rst) |-> port0_pin_o == 8'hFF && port1_pin_o == 8'hFF && port0_pin_oe == 8'h00 && port1_pin_oe == 8'h00;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("ports not at reset value");
  property p_ack_wait;
    $fell(rst) |-> !sda_oe [*8];
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("data line driven after reset");
  property p_oe1_gap;
    $changed(port1_pin_oe) |=> s_oe1_hold;
  endproperty
  a_oe1_gap: assert property (p_oe1_gap) else $error("direction changed twice");
  property p_out0_gap;
    $changed(port0_pin_o) |=> $stable(port0_pin_o) [*8];
  endproperty
  a_out0_gap: assert property (p_out0_gap) else $error("latch changed twice");
  property p_out_scl;
    $changed(port0_pin_o) || $changed(port1_pin_o) || $changed(port0_pin_oe) || $changed(port1_pin_oe) |-> !scl_i;
  endproperty
  a_out_scl: assert property (p_out_scl) else $error("port changed with clock high");
  property p_sda_low;
    $changed(sda_oe) |-> !scl_i;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data changed with clock high");
  property p_sda_hold;
    $rose(scl_i) |-> $stable(sda_oe) [*5];
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("data not held");
  property p_start_free;
    scl_i && $fell(sda_i) |-> !sda_oe;
  endproperty
  a_start_free: assert property (p_start_free) else $error("device drove a start");
endmodule
`default_nettype wire

//--- tb/ioexp_master.sv
`timescale 1ns/10ps
`default_nettype none
// Bus master model: open-drain data, clock stands high between frames.
module ioexp_master (
  input  wire logic ref_clk,
  input  wire logic sda_in,
  output var logic  scl,
  output var logic  sda_drv
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // A third of a bus clock; long enough for the two-stage synchronisers.
  task automatic hp;
    repeat (6) @(negedge ref_clk);
  endtask
  // Also serves as repeated start, so data rises before the clock does.
  task automatic start;
    sda_drv = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b0;
    hp;
    scl = 1'b0;
    hp;
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b1;
    hp;
  endtask
  // Eight bits first-bit-7, then the ninth bit; a one releases the line.
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, a};
    for (int i = 8; i >= 0; i--)
    begin
      sda_drv = s[i];
      hp;
      scl = 1'b1;
      hp;
      r[i] = sda_in;
      scl = 1'b0;
      hp;
    end
    q = r[8:1];
    ack = r[0];
  endtask
endmodule
`default_nettype wire

//--- tb/ioexp_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ioexp_regs_bench;
  import ioexp_pkg::*;
  logic            ref_clk = 1'b0;
  logic            rst = 1'b1;
  logic [7:0]      ext0 = 8'h96;
  logic [7:0]      ext1 = 8'h71;
  int              bad_count = 0;
  int              n_tests = 0;
  wire logic       scl, sda_drv, sda_o, sda_oe;
  wire logic [7:0] p0_o, p0_oe, p1_o, p1_oe;
  // Pull-up on the data line; a pin shows the driver wherever it is enabled.
  wire logic       sda = sda_drv & (sda_oe ? sda_o : 1'b1);
  wire logic [7:0] p0 = (p0_oe & p0_o) | (~p0_oe & ext0);
  wire logic [7:0] p1 = (p1_oe & p1_o) | (~p1_oe & ext1);
  always #50 ref_clk = ~ref_clk;
  ioexp_regs DUT (.ref_clk(ref_clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .port0_pin_i(p0), .port1_pin_i(p1), .port0_pin_o(p0_o), .port0_pin_oe(p0_oe), .port1_pin_o(p1_o),
    .port1_pin_oe(p1_oe));
  ioexp_master m (.ref_clk(ref_clk), .sda_in(sda), .scl(scl), .sda_drv(sda_drv));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Two bytes from cmd on; every byte must be acknowledged.
  task automatic wr2(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] q;
    logic [3:0] k;
    m.start;
    m.xfer({SLAVE_ADDR, 1'b0}, 1'b1, q, k[0]);
    m.xfer(cmd, 1'b1, q, k[1]);
    m.xfer(a, 1'b1, q, k[2]);
    m.xfer(b, 1'b1, q, k[3]);
    m.stop;
    check({4'h0, k}, 8'h00);
  endtask
  // Sets the pointer, restarts and reads both registers of the pair.
  task automatic rd2(input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] q0, q1, q;
    logic [3:0] k;
    m.start;
    m.xfer({SLAVE_ADDR, 1'b0}, 1'b1, q, k[0]);
    m.xfer(cmd, 1'b1, q, k[1]);
    m.start;
    m.xfer({SLAVE_ADDR, 1'b1}, 1'b1, q, k[2]);
    m.xfer(8'hFF, 1'b0, q0, k[3]);
    m.xfer(8'hFF, 1'b1, q1, k[3]);
    m.stop;
    check({5'h00, k[2:0]}, 8'h00);
    check(q0, e0);
    check(q1, e1);
  endtask
  task automatic t_reset;
    check(p0_o, 8'hFF);
    check(p1_oe, 8'h00);
    rd2(CMD_OUT1, 8'hFF, 8'hFF);
    rd2(CMD_INV0, 8'h00, 8'h00);
    rd2(CMD_DIR1, 8'hFF, 8'hFF);
  endtask
  task automatic t_pairs;
    wr2(CMD_DIR1, 8'h0F, 8'hFF);
    check(p1_oe, 8'hF0);
    check(p0_oe, 8'h00);
    wr2(CMD_OUT0, 8'hA5, 8'h3C);
    check(p0_o, 8'hA5);
    check(p1_o, 8'h3C);
    rd2(CMD_IN1, 8'h31, 8'h96);
    rd2(CMD_OUT1, 8'h3C, 8'hA5);
  endtask
  task automatic t_invert;
    wr2(CMD_INV0, 8'hF0, 8'h0F);
    rd2(CMD_INV1, 8'h0F, 8'hF0);
    rd2(CMD_IN0, 8'h66, 8'h3E);
    wr2(CMD_DIR0, 8'h00, 8'h0F);
    check(p0_oe, 8'hFF);
    rd2(CMD_IN0, 8'hA5, 8'h3E);
  endtask
  task automatic t_refuse;
    logic [7:0] q;
    logic       k;
    wr2(CMD_IN0, 8'h00, 8'h00);
    rd2(CMD_IN0, 8'hA5, 8'h3E);
    wr2(8'h0A, 8'h00, 8'h00);
    rd2(8'hFF, 8'h00, 8'h00);
    rd2(CMD_OUT0, 8'hA5, 8'h3C);
    m.start;
    m.xfer({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, q, k);
    m.stop;
    check({7'h00, k}, 8'h01);
    // A read with no command byte starts at the stored pointer, here the port 0 latch.
    m.start;
    m.xfer({SLAVE_ADDR, 1'b1}, 1'b1, q, k);
    check({7'h00, k}, 8'h00);
    m.xfer(8'hFF, 1'b1, q, k);
    m.stop;
    check(q, 8'hA5);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence: reset, then each scenario in turn.
  initial
  begin
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    t_reset;
    t_pairs;
    t_invert;
    t_refuse;
    final_report;
  end
  // The run needs about one and a half milliseconds; a hang stops well after that.
  initial
  begin
    #6_000_000;
    bad_count++;
    final_report;
  end
endmodule
bind ioexp_regs ioexp_asserts u_chk (
  .ref_clk      (ref_clk),
  .rst          (rst),
  .scl_i        (scl_i),
  .sda_i        (sda_i),
  .sda_oe       (sda_oe),
  .port0_pin_o  (port0_pin_o),
  .port0_pin_oe (port0_pin_oe),
  .port1_pin_o  (port1_pin_o),
  .port1_pin_oe (port1_pin_oe)
);
`default_nettype wire
